/* File: verilog/timer_zero_map.vh */
`ifndef TIMER_ZERO_MAP_VH
`define TIMER_ZERO_MAP_VH
// ==========================================================
// Register byte addresses
`define ADDR_MODE        4'h0
`define ADDR_CONTROL     4'h4
`define ADDR_COUNT_LOW   4'h8
`define ADDR_COUNT_HIGH  4'hc
// ==========================================================
// Mode register fields (lower nibble)
`define MODE_SEL_LSB     0
`define MODE_SEL_MSB     1
`define MODE_CNT_BIT     2
`define MODE_GATE_BIT    3
// ==========================================================
// Control register fields
`define CTRL_INT_TYPE    0
`define CTRL_INT_FLAG    1
`define CTRL_RUN0        4
`define CTRL_OVF0        5
`define CTRL_RUN1        6
`define CTRL_OVF1        7
// ==========================================================
// Mode codes
`define MODE_13BIT       2'h0
`define MODE_16BIT       2'h1
`define MODE_RELOAD      2'h2
`define MODE_SPLIT       2'h3
// ==========================================================
// Reset values, timing and bus response codes
`define RST_BYTE         8'h00
`define PER_CLKS         6
`define PRESCALE_MASK    8'h1f
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`endif

/* File: verilog/pin_sync.v */
// ==========================================================
// Two-flop synchroniser for one asynchronous pin
module pin_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire din,
  output reg  dout_ff
);
  reg meta_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end
endmodule // pin_sync

/* File: verilog/timer_counter_zero.v */
`include "timer_zero_map.vh"

module timer_counter_zero #(
  parameter PER_DIV = `PER_CLKS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire        count_pin,
  input  wire        gate_pin_zero,
  input  wire        int_ack_zero,
  input  wire        int_ack_one,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq_zero_ff,
  output reg         irq_one_ff
);
  // ==========================================================
  // Registers
  reg [7:0] timer_mode_reg;
  reg [7:0] timer_control_reg;
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [2:0] div_ff;
  reg       cnt_prev_ff;
  reg       aw_ff;
  reg       w_ff;
  reg [3:0] awaddr_ff;
  reg [7:0] wbyte_ff;

  // Both pins share one synchroniser shape; bit 0 is the count pin
  wire [1:0] pin_raw = {gate_pin_zero, count_pin};
  wire [1:0] pin_safe;
  genvar     gi;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     (pin_raw[gi]),
        .dout_ff (pin_safe[gi])
      );
    end
  endgenerate

  wire count_sync = pin_safe[0];
  wire gate_sync  = pin_safe[1];

  // ==========================================================
  // Control decode
  wire [1:0] mode_sel  = timer_mode_reg[`MODE_SEL_MSB:`MODE_SEL_LSB];
  wire       cnt_sel   = timer_mode_reg[`MODE_CNT_BIT];
  wire       gate_sel  = timer_mode_reg[`MODE_GATE_BIT];
  wire       run_zero  = timer_control_reg[`CTRL_RUN0];
  wire       run_one   = timer_control_reg[`CTRL_RUN1];

  // Peripheral cycle strobe; the peripheral clock is aclk, so the
  // tick is aclk/6 which is osc/12 or osc/6 in double speed mode.
  wire per_tick = (div_ff == PER_DIV - 1);

  // A fall is seen only when consecutive per-cycle samples go 1 then 0,
  // so a full pulse takes two peripheral cycles to register.
  wire fall_tick = per_tick && cnt_prev_ff && !count_sync;

  // Gate pin only matters when gating is selected
  wire enable_zero = run_zero && (!gate_sel || gate_sync);
  wire inc_zero    = enable_zero && (cnt_sel ? fall_tick : per_tick);
  wire inc_one     = (mode_sel == `MODE_SPLIT) && run_one && per_tick;

  // ==========================================================
  // Counter next-state
  reg [7:0] nxt_low;
  reg [7:0] nxt_high;
  reg       ovf_zero;
  reg       ovf_one;

  always @* begin
    nxt_low  = count_low_byte;
    nxt_high = count_high_byte;
    ovf_zero = 1'b0;
    ovf_one  = 1'b0;
    if (inc_zero) begin
      case (mode_sel)
        `MODE_13BIT: begin
          // Upper three low bits are left as they were and carry no meaning
          nxt_low[4:0] = count_low_byte[4:0] + 5'h01;
          if (count_low_byte[4:0] == 5'h1f) begin
            nxt_high = count_high_byte + 8'h01;
            ovf_zero = (count_high_byte == 8'hff);
          end
        end
        `MODE_16BIT: begin
          nxt_low = count_low_byte + 8'h01;
          if (count_low_byte == 8'hff) begin
            nxt_high = count_high_byte + 8'h01;
            ovf_zero = (count_high_byte == 8'hff);
          end
        end
        `MODE_RELOAD: begin
          if (count_low_byte == 8'hff) begin
            nxt_low  = count_high_byte;
            ovf_zero = 1'b1;
          end else begin
            nxt_low = count_low_byte + 8'h01;
          end
        end
        `MODE_SPLIT: begin
          // High byte is handled below under the borrowed run bit
          nxt_low  = count_low_byte + 8'h01;
          ovf_zero = (count_low_byte == 8'hff);
        end
        default: begin
          nxt_low = count_low_byte;
        end
      endcase
    end
    if (inc_one) begin
      nxt_high = count_high_byte + 8'h01;
      ovf_one  = (count_high_byte == 8'hff);
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  // Address and data are parked in either order; readies stay low until the
  // response is taken, which keeps exactly one write in flight.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_ff || aw_take;
  wire w_have  = w_ff || w_take;
  wire [3:0] wa = aw_take ? s_axi_awaddr : awaddr_ff;
  wire [7:0] wd = w_take ? s_axi_wdata[7:0] : wbyte_ff;
  wire       wl = w_take ? s_axi_wstrb[0] : 1'b1;
  wire do_wr   = aw_have && w_have && !s_axi_bvalid;
  wire wr_ok   = (wa == `ADDR_MODE) || (wa == `ADDR_CONTROL) ||
                 (wa == `ADDR_COUNT_LOW) || (wa == `ADDR_COUNT_HIGH);
  reg  wlane_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_ff         <= 1'b0;
      w_ff          <= 1'b0;
      awaddr_ff     <= 4'h0;
      wbyte_ff      <= `RST_BYTE;
      wlane_ff      <= 1'b0;
    end else if (ce) begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_ff         <= 1'b0;
        w_ff          <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else begin
        if (aw_take) begin
          aw_ff         <= 1'b1;
          s_axi_awready <= 1'b0;
        end
        if (w_take) begin
          w_ff         <= 1'b1;
          s_axi_wready <= 1'b0;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  wire lane0 = w_take ? wl : wlane_ff;
  wire wr_en = do_wr && lane0;

  // ==========================================================
  // Timer state; software writes win over counting in the same cycle,
  // but flag sets beat software clears.
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_reg    <= `RST_BYTE;
      timer_control_reg <= `RST_BYTE;
      count_low_byte    <= `RST_BYTE;
      count_high_byte   <= `RST_BYTE;
      div_ff            <= 3'h0;
      cnt_prev_ff       <= 1'b0;
      irq_zero_ff       <= 1'b0;
      irq_one_ff        <= 1'b0;
    end else if (ce) begin
      // Divider free-runs regardless of run, so tick phase never follows software
      div_ff <= per_tick ? 3'h0 : div_ff + 3'h1;
      if (per_tick) begin
        cnt_prev_ff <= count_sync;
      end
      // Run bit never touches the count bytes
      count_low_byte  <= (wr_en && wa == `ADDR_COUNT_LOW) ? wd : nxt_low;
      count_high_byte <= (wr_en && wa == `ADDR_COUNT_HIGH) ? wd : nxt_high;
      if (wr_en && wa == `ADDR_MODE) begin
        timer_mode_reg <= wd;
      end
      if (wr_en && wa == `ADDR_CONTROL) begin
        timer_control_reg <= wd;
      end
      if (int_ack_zero && !ovf_zero) begin
        timer_control_reg[`CTRL_OVF0] <= 1'b0;
      end
      if (int_ack_one && !ovf_one) begin
        timer_control_reg[`CTRL_OVF1] <= 1'b0;
      end
      // Sets come last so an overflow beside an acknowledge or a clear is kept
      if (ovf_zero) begin
        timer_control_reg[`CTRL_OVF0] <= 1'b1;
      end
      if (ovf_one) begin
        timer_control_reg[`CTRL_OVF1] <= 1'b1;
      end
      irq_zero_ff <= timer_control_reg[`CTRL_OVF0];
      irq_one_ff  <= timer_control_reg[`CTRL_OVF1];
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  // Count bytes are read live; a running 16-bit count can tear between the two
  // byte reads, so software should stop the timer or re-read the high byte.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `AXI_OKAY;
        case (s_axi_araddr)
          `ADDR_MODE:       s_axi_rdata <= {24'h000000, timer_mode_reg};
          `ADDR_CONTROL:    s_axi_rdata <= {24'h000000, timer_control_reg};
          `ADDR_COUNT_LOW:  s_axi_rdata <= {24'h000000, count_low_byte};
          `ADDR_COUNT_HIGH: s_axi_rdata <= {24'h000000, count_high_byte};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // timer_counter_zero

/* File: testbench/timer_counter_zero_monitor.sv */
// ==========================================================
// Bus handshake checks at the top ports
module timer_counter_zero_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire        ce,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready && ce |=> !s_axi_awready)
    else $error("awready high after address taken");
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && ce |=> s_axi_bvalid) else $error("no write response");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready && ce |=>
    s_axi_awready && s_axi_wready) else $error("readies not restored");
  a_ar_refused: assert property (s_axi_arvalid && s_axi_arready && ce |=> !s_axi_arready)
    else $error("arready high after address taken");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("no read data");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte");
endmodule // timer_counter_zero_monitor

/* File: testbench/event_source.sv */
// ==========================================================
// External pulse and gate source
module event_source (
  input  wire  aclk,
  output logic count_pin,
  output logic gate_pin_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    count_pin = 1'b0;
    gate_pin_zero = 1'b0;
  end
  // Hold below six clocks would let a level slip between samples
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      @(posedge aclk);
      count_pin <= 1'b1;
      repeat (hold) @(posedge aclk);
      count_pin <= 1'b0;
      repeat (hold - 1) @(posedge aclk);
    end
  endtask
  task automatic set_gate(input logic v);
    @(posedge aclk);
    gate_pin_zero <= v;
  endtask
endmodule // event_source

/* File: testbench/timer_counter_zero_bench.sv */
`include "timer_zero_map.vh"
// ==========================================================
// Register-level tests
module timer_counter_zero_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, cp, gp, bvalid, awready, wready, arready, rvalid, irq0, irq1;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ack0 = 1'b0, ack1 = 1'b0, ce_in = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, r, b;
  logic [7:0]  v;
  int          n_fail = 0, compares = 0;
  // Entry: mode, low, high, run bits, low after, high after, control after
  localparam logic [55:0] tbl [5] = '{56'h00_1f_ff_10_00_00_20, 56'h01_ff_ff_10_00_00_20,
    56'h02_ff_80_10_80_80_20, 56'h03_ff_37_10_00_37_20, 56'h03_00_ff_40_00_00_80};
  event_source src (.aclk(aclk), .count_pin(cp), .gate_pin_zero(gp));
  timer_counter_zero dut (.aclk(aclk), .aresetn(aresetn), .ce(ce_in), .count_pin(cp),
    .gate_pin_zero(gp), .int_ack_zero(ack0), .int_ack_one(ack1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_zero_ff(irq0), .irq_one_ff(irq1));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is raised only once valid is seen, so the slave must hold its answer a cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    b = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    v = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    check(v, exp);
  endtask
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    // Roughly four times the length of a clean run
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 16; a += 4) rchk(a[3:0], 8'h00);
    rd(4'h2);
    check({6'h0, r}, {6'h0, `AXI_SLVERR});
    $display("test reset and map done");
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_MODE, tbl[i][55:48]);
      wr(`ADDR_COUNT_LOW, tbl[i][47:40]);
      wr(`ADDR_COUNT_HIGH, tbl[i][39:32]);
      wr(`ADDR_CONTROL, tbl[i][31:24]);
      for (int k = 0; k < 40 && !(irq0 || irq1); k++) @(posedge aclk);
      // Stopping here keeps the flag and lands before the next tick
      wr(`ADDR_CONTROL, tbl[i][7:0]);
      rd(`ADDR_COUNT_LOW);
      check(v & (i == 0 ? 8'h1f : 8'hff), tbl[i][23:16]);
      rchk(`ADDR_COUNT_HIGH, tbl[i][15:8]);
      rchk(`ADDR_CONTROL, tbl[i][7:0]);
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      @(posedge aclk);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      rchk(`ADDR_CONTROL, 8'h00);
      check({6'h0, irq0, irq1}, 8'h00);
      $display("test mode entry %0d done", i);
    end
    wr(`ADDR_MODE, 8'h01);
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h10);
    // Frozen cycles must add no ticks; 30 keeps the tick phase of later tests
    ce_in <= 1'b0;
    repeat (30) @(posedge aclk);
    ce_in <= 1'b1;
    repeat (60) @(posedge aclk);
    wr(`ADDR_CONTROL, 8'h00);
    rd(`ADDR_COUNT_LOW);
    check({7'h0, v inside {8'd10, 8'd11}}, 8'h01);
    $display("test tick rate done");
    wr(`ADDR_MODE, 8'h05);
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h10);
    src.pulses(3, 6);
    repeat (24) @(posedge aclk);
    rchk(`ADDR_COUNT_LOW, 8'h03);
    wr(`ADDR_CONTROL, 8'h00);
    check({6'h0, b}, {6'h0, `AXI_OKAY});
    wr(`ADDR_MODE, 8'h0d);
    wr(`ADDR_COUNT_LOW, 8'h00);
    wr(`ADDR_CONTROL, 8'h10);
    src.pulses(2, 12);
    repeat (24) @(posedge aclk);
    rchk(`ADDR_COUNT_LOW, 8'h00);
    src.set_gate(1'b1);
    src.pulses(2, 12);
    repeat (24) @(posedge aclk);
    rchk(`ADDR_COUNT_LOW, 8'h02);
    $display("test counter and gate done");
    wstrb <= 4'h0;
    wr(`ADDR_CONTROL, 8'h00);
    rchk(`ADDR_CONTROL, 8'h10);
    wstrb <= 4'hf;
    wr(4'h2, 8'hff);
    check({6'h0, b}, {6'h0, `AXI_SLVERR});
    $display("test strobe and error done");
    finish_test();
  end
endmodule // timer_counter_zero_bench
bind timer_counter_zero timer_counter_zero_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
